// ---- shared/bridge_cfg_map.vh ----
// Purpose: offsets, field positions, reset values and timing counts for the
//          bridge configuration dwords 0ch, 18h and 1ch.
// Assumes: byte offsets on a 32-bit configuration port.
// Notes:   included by both design files.
`ifndef BRIDGE_CFG_MAP_VH
`define BRIDGE_CFG_MAP_VH

`define OFS_LAT_HDR       8'h0c
`define OFS_BUS_NUMS      8'h18
`define OFS_IO_BASE       8'h1c

`define POS_PRI_LAT       8
`define POS_HDR_TYPE      16
`define POS_PRI_BUS       0
`define POS_SEC_BUS       8
`define POS_SUB_BUS       16
`define POS_SEC_LAT       24
`define POS_IO_IND        0
`define POS_IO_BASE       4

`define HDR_TYPE_VAL      8'h01
`define IO_IND_VAL        4'h1
`define RST_BYTE          8'h00
`define RST_NIB           4'h0

`define LAT_ZERO          8'h00

`endif

// ---- src/latency_timer.v ----
// Purpose: master latency timer for one bus side.
// Assumes: i_tick is one pulse per bus clock, from the bridge clock domain.
// Notes:   expiry is a level that holds until the frame ends.
`timescale 1ns/1ps
`include "bridge_cfg_map.vh"
module latency_timer
(
    input  wire       i_ref_clk,
    input  wire       i_reset,
    input  wire       i_tick,
    input  wire       i_frame_start,
    input  wire       i_frame_active,
    input  wire [7:0] i_setting,
    output reg        o_expired,
    output reg  [7:0] o_count
);
    // =============================================================
    // counter
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_count   <= `RST_BYTE;
            o_expired <= 1'b0;
        end
        else if (i_frame_start)
        begin
            o_count   <= i_setting;
            o_expired <= (i_setting == `LAT_ZERO);
        end
        else if (!i_frame_active)
        begin
            o_expired <= 1'b0;
        end
        else if (i_tick && !o_expired)
        begin
            if (o_count <= 8'h01)
            begin
                o_count   <= `RST_BYTE;
                o_expired <= 1'b1;
            end
            else
            begin
                o_count <= o_count - 8'h01;
            end
        end
    end
endmodule // latency_timer

// ---- src/bridge_cfg_header.v ----
// Purpose: configuration dwords 0ch, 18h, 1ch of a two-port bridge, with
//          master latency timers and forwarding values for the decoders.
// Assumes: frame and grant inputs come from the bridge's own master logic
//          on i_ref_clk; i_bus_tick is a one-cycle bus clock enable.
// Notes:   bits 7:0 and 31:24 of 0ch and upper 24 bits of 1ch belong elsewhere.
`timescale 1ns/1ps
`include "bridge_cfg_map.vh"
module bridge_cfg_header
(
    input  wire        i_ref_clk,
    input  wire        i_reset,
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_byte_en,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    input  wire        i_bus_tick,
    input  wire        i_pri_frame_start,
    input  wire        i_pri_frame_active,
    input  wire        i_sec_frame_start,
    input  wire        i_sec_frame_active,
    input  wire        i_sec_data_done,
    input  wire        i_sec_grant,
    input  wire        i_sec_mwi,
    input  wire [15:0] i_io_base_upper,
    output wire        o_pri_lat_expired,
    output wire        o_sec_lat_expired,
    output wire        o_sec_stop,
    output wire [7:0]  o_pri_bus,
    output wire [7:0]  o_sec_bus,
    output wire [7:0]  o_sub_bus,
    output wire [31:0] o_io_base_addr
);
    reg  [7:0] pri_lat;
    reg  [7:0] pri_bus;
    reg  [7:0] sec_bus;
    reg  [7:0] sub_bus;
    reg  [7:0] sec_lat;
    reg  [3:0] io_base;
    wire       sec_timer_exp;

    // =============================================================
    // byte merge helper
    function [7:0] merge_byte;
        input [7:0] old_val;
        input [7:0] new_val;
        input       en;
        begin
            merge_byte = en ? new_val : old_val;
        end
    endfunction

    // =============================================================
    // register writes
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            pri_lat <= `RST_BYTE;
            pri_bus <= `RST_BYTE;
            sec_bus <= `RST_BYTE;
            sub_bus <= `RST_BYTE;
            sec_lat <= `RST_BYTE;
            io_base <= `RST_NIB;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `OFS_LAT_HDR:
                begin
                    pri_lat <= merge_byte(pri_lat, i_wdata[`POS_PRI_LAT +: 8], i_byte_en[1]);
                end
                `OFS_BUS_NUMS:
                begin
                    pri_bus <= merge_byte(pri_bus, i_wdata[`POS_PRI_BUS +: 8], i_byte_en[0]);
                    sec_bus <= merge_byte(sec_bus, i_wdata[`POS_SEC_BUS +: 8], i_byte_en[1]);
                    sub_bus <= merge_byte(sub_bus, i_wdata[`POS_SUB_BUS +: 8], i_byte_en[2]);
                    sec_lat <= merge_byte(sec_lat, i_wdata[`POS_SEC_LAT +: 8], i_byte_en[3]);
                end
                `OFS_IO_BASE:
                begin
                    if (i_byte_en[0])
                    begin
                        io_base <= i_wdata[`POS_IO_BASE +: 4];
                    end
                end
                default:
                begin
                    io_base <= io_base;
                end
            endcase
        end
    end

    // =============================================================
    // read data, one cycle after the strobe
    always @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            o_rdata <= 32'h00000000;
        end
        else if (i_rd)
        begin
            case (i_addr)
                `OFS_LAT_HDR:  o_rdata <= {8'h00, `HDR_TYPE_VAL, pri_lat, 8'h00};
                `OFS_BUS_NUMS: o_rdata <= {sec_lat, sub_bus, sec_bus, pri_bus};
                `OFS_IO_BASE:  o_rdata <= {24'h000000, io_base, `IO_IND_VAL};
                default:       o_rdata <= 32'h00000000;
            endcase
        end
        else
        begin
            // read data stands one cycle only
            o_rdata <= 32'h00000000;
        end
    end

    // =============================================================
    // latency timers
    // primary timer setting
    latency_timer u_pri_timer
    (
        .i_ref_clk      (i_ref_clk),
        .i_reset        (i_reset),
        .i_tick         (i_bus_tick),
        .i_frame_start  (i_pri_frame_start),
        .i_frame_active (i_pri_frame_active),
        .i_setting      (pri_lat),
        .o_expired      (o_pri_lat_expired),
        .o_count        ()
    );

    latency_timer u_sec_timer
    (
        .i_ref_clk      (i_ref_clk),
        .i_reset        (i_reset),
        .i_tick         (i_bus_tick),
        .i_frame_start  (i_sec_frame_start),
        .i_frame_active (i_sec_frame_active),
        .i_setting      (sec_lat),
        .o_expired      (sec_timer_exp),
        .o_count        ()
    );

    assign o_sec_lat_expired = sec_timer_exp;

    // =============================================================
    // secondary termination request
    // stop on timer expiry unless i_sec_grant or i_sec_mwi is set; at zero latency only once i_sec_data_done is set
    assign o_sec_stop = i_sec_frame_active && sec_timer_exp && !i_sec_grant && !i_sec_mwi
                        && ((sec_lat != `LAT_ZERO) || i_sec_data_done);

    // =============================================================
    // forwarding values
    assign o_pri_bus = pri_bus;
    assign o_sec_bus = sec_bus;
    assign o_sub_bus = sub_bus;
    assign o_io_base_addr = {i_io_base_upper, io_base, 12'h000};
endmodule // bridge_cfg_header

// ---- verif/cfg_hdr_monitor.sv ----
// Purpose: port assertions for the bridge config header
// Assumes: one clock, synchronous active-high reset
// Notes:   bound below to every bridge_cfg_header
`timescale 1ns/1ps
module cfg_hdr_monitor
(
    input wire        i_ref_clk,
    input wire        i_reset,
    input wire [7:0]  i_addr,
    input wire [31:0] i_wdata,
    input wire [3:0]  i_byte_en,
    input wire        i_wr,
    input wire        i_rd,
    input wire [31:0] o_rdata,
    input wire        i_sec_grant,
    input wire        i_sec_mwi,
    input wire [15:0] i_io_base_upper,
    input wire        o_sec_stop,
    input wire [7:0]  o_pri_bus,
    input wire [7:0]  o_sec_bus,
    input wire [7:0]  o_sub_bus,
    input wire [31:0] o_io_base_addr
);
    // ==========
    // field checks
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    wire bus_wr = i_wr && i_addr == 8'h18;
    hdr_type_a: assert property (i_rd && i_addr == 8'h0c |=> o_rdata[23:16] == 8'h01)
        else $error("header type not fixed");
    io_ind_a: assert property (i_rd && i_addr == 8'h1c |=> o_rdata[3:0] == 4'h1)
        else $error("io width indicator not fixed");
    pri_bus_a: assert property (bus_wr && i_byte_en[0] |=> o_pri_bus == $past(i_wdata[7:0]))
        else $error("primary bus number not written");
    sec_bus_a: assert property (bus_wr && i_byte_en[1] |=> o_sec_bus == $past(i_wdata[15:8]))
        else $error("secondary bus number not written");
    sub_bus_a: assert property (bus_wr && i_byte_en[2] |=> o_sub_bus == $past(i_wdata[23:16]))
        else $error("subordinate bus number not written");
    io_nib_a: assert property (i_wr && i_addr == 8'h1c && i_byte_en[0]
        |=> o_io_base_addr[15:12] == $past(i_wdata[7:4])) else $error("io base not written");
    io_form_a: assert property (o_io_base_addr[31:16] == i_io_base_upper
        && o_io_base_addr[11:0] == 12'h000) else $error("io base address malformed");
    stop_cause_a: assert property (o_sec_stop |-> !i_sec_grant && !i_sec_mwi)
        else $error("stop while granted or mwi");
endmodule // cfg_hdr_monitor
bind bridge_cfg_header cfg_hdr_monitor u_mon (.*);

// ---- verif/bridge_cfg_header_tb.sv ----
// Purpose: self-checking bench for bridge_cfg_header
// Assumes: 250 MHz clock, reset held five cycles
// Notes:   shadow model keeps each dword with its fixed fields
`timescale 1ns/1ps
module bridge_cfg_header_tb;
    reg         i_ref_clk = 1'h0, i_reset = 1'h1, i_wr = 1'h0, i_rd = 1'h0, i_bus_tick = 1'h0;
    reg         i_pri_frame_start = 1'h0, i_pri_frame_active = 1'h0, i_sec_grant = 1'h0;
    reg         i_sec_frame_start = 1'h0, i_sec_frame_active = 1'h0, i_sec_data_done = 1'h0;
    reg         i_sec_mwi = 1'h0;
    reg  [7:0]  i_addr = 8'h00;
    reg  [31:0] i_wdata = 32'h0, seed = 32'hde3d;
    reg  [3:0]  i_byte_en = 4'h0;
    reg  [15:0] i_io_base_upper = 16'h0;
    wire [31:0] o_rdata, o_io_base_addr;
    wire [7:0]  o_pri_bus, o_sec_bus, o_sub_bus;
    wire        o_pri_lat_expired, o_sec_lat_expired, o_sec_stop;
    reg  [31:0] m [0:3];
    integer     mismatches = 0, n_tests = 0, i;
    bridge_cfg_header u_dut (.*);
    always #2 i_ref_clk = ~i_ref_clk;
    // ==========
    // helpers
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function [7:0] at(input [1:0] k);
        at = (k == 2'h0) ? 8'h0c : (k == 2'h1) ? 8'h18 : (k == 2'h2) ? 8'h1c : 8'h20;
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp)
            begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [1:0] k, input [31:0] d, input [3:0] be);
        reg [31:0] msk;
        begin
            msk = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
            // fixed fields and unmapped space never take writes
            msk = msk & ((k == 2'h0) ? 32'hff00 : (k == 2'h1) ? 32'hffffffff
                : (k == 2'h2) ? 32'hf0 : 32'h0);
            m[k] = (m[k] & ~msk) | (d & msk);
            i_wr <= 1'h1;
            i_addr <= at(k);
            i_wdata <= d;
            i_byte_en <= be;
            @(posedge i_ref_clk);
            i_wr <= 1'h0;
        end
    endtask
    task rd(input [1:0] k);
        begin
            i_rd <= 1'h1;
            i_addr <= at(k);
            @(posedge i_ref_clk);
            i_rd <= 1'h0;
            // read data stands only in the cycle after the strobe edge
            #1 chk(o_rdata, m[k]);
            @(posedge i_ref_clk);
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // ==========
    // tests
    initial
    begin
        m[0] = 32'h10000;
        m[1] = 32'h0;
        m[2] = 32'h1;
        m[3] = 32'h0;
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'h0;
        for (i = 0; i < 4; i = i + 1)
            rd(i[1:0]);
        $display("reset values done");
        for (i = 0; i < 40; i = i + 1)
        begin
            seed = xs(seed);
            wr(seed[1:0], xs(seed), seed[7:4]);
            rd(seed[9:8]);
            chk(o_io_base_addr, {i_io_base_upper, m[2][7:4], 12'h000});
            i_io_base_upper <= seed[31:16];
        end
        $display("register access done");
        wr(2'h0, 32'h300, 4'h2);
        i_pri_frame_start <= 1'h1;
        i_pri_frame_active <= 1'h1;
        @(posedge i_ref_clk);
        i_pri_frame_start <= 1'h0;
        i_bus_tick <= 1'h1;
        repeat (2) @(posedge i_ref_clk);
        #1 chk(o_pri_lat_expired, 32'h0);
        @(posedge i_ref_clk);
        #1 chk(o_pri_lat_expired, 32'h1);
        wr(2'h1, 32'h0, 4'h8);
        {i_sec_frame_start, i_sec_frame_active, i_sec_data_done, i_sec_mwi} <= 4'hf;
        @(posedge i_ref_clk);
        i_sec_frame_start <= 1'h0;
        #1 chk({o_sec_lat_expired, o_sec_stop}, 32'h2);
        i_sec_mwi <= 1'h0;
        #1 chk(o_sec_stop, 32'h1);
        i_sec_grant <= 1'h1;
        #1 chk(o_sec_stop, 32'h0);
        {i_sec_grant, i_sec_data_done} <= 2'h0;
        #1 chk(o_sec_stop, 32'h0);
        $display("latency timers done");
        tally_and_finish;
    end
    // run needs about 150 cycles, so 5000 means a hang
    initial
    begin
        #20000;
        mismatches = mismatches + 1;
        tally_and_finish;
    end
endmodule // bridge_cfg_header_tb
